//--- pmra_result_alert.v
// Summary of operation
// - Shunt result: signed 16 bits, range-scaled
// - Bus result: 16 bits, never negative
// - Temperature in bits 15-4, low nibble zero
// - Current result read-only, signed 16 bits
// - Power result read-only, unsigned 24 bits
// - Transparent mode: flags follow fault condition
// - Latched mode: flags hold until diag read
// - Ready-on-pin routes ready flag to alert
// - Compare raw samples or averaged result
// - Polarity bit selects active-low or active-high alert
// - Reserved diag bits read zero
// - Overflow flag set by math, cleared by trigger
// - Over-temperature flag on temperature above limit
// - Shunt over-limit flag
// - Shunt under-limit flag
// - Bus over-limit flag
// - Bus under-limit flag
// - Power over-limit flag
// - Latched limit flags clear on diag read
// - Ready flag: set on completion, clear on read/trigger
// - Memory-ok bit low after trim checksum error
// - Results update only after averaging completes
`timescale 1ns/1ps
`default_nettype none
`include "pmra_defs_regs.vh"

module pmra_result_alert (
    input wire core_clk,               // 200 MHz system clock
    input wire rst_b,                  // Asynchronous reset, active low
    // Documented register port
    input wire [7:0] regAddr,          // Register offset
    input wire regRdStrobe,            // One-cycle read request
    input wire regWrStrobe,            // One-cycle write request
    input wire [15:0] regWrData,       // Write data
    output reg [15:0] regRdData,       // Read data, valid cycle after strobe
    output reg [7:0] regRdDataHi,      // Power bits 23-16, else zero
    // Converter side
    input wire [2:0] rawValid,         // Raw sample strobes: 0 shunt, 1 bus, 2 temp
    input wire [15:0] rawShunt,        // Raw shunt sample
    input wire [15:0] rawBus,          // Raw bus sample
    input wire [11:0] rawTemp,         // Raw temperature sample
    input wire resultValid,            // Averaged conversion complete
    input wire [2:0] resultChan,       // Channels active in this result
    input wire [15:0] avgShunt,        // Averaged shunt voltage
    input wire [15:0] avgBus,          // Averaged bus voltage
    input wire [11:0] avgTemp,         // Averaged temperature
    input wire [15:0] calcCurrent,     // Computed current
    input wire [23:0] calcPower,       // Computed power
    input wire mathOverflow,           // Overflow in current or power math
    input wire convTrigger,            // New triggered conversion starts
    input wire trimChecksumError,      // Trim memory checksum failure
    input wire shuntRangeSelect,       // Shunt scale, kept by the converter
    // Threshold values from the limit registers
    input wire [15:0] shuntOverLim,    // Shunt over-limit
    input wire [15:0] shuntUnderLim,   // Shunt under-limit
    input wire [15:0] busOverLim,      // Bus over-limit
    input wire [15:0] busUnderLim,     // Bus under-limit
    input wire [11:0] tempOverLim,     // Temperature over-limit
    input wire [23:0] powerOverLim,    // Power over-limit
    // Open-drain alert pin
    output wire alertPinOut,           // Pin output level, always low
    output reg alertPinOe,             // High while pulling the pin low
    output reg alertActive             // Alert condition, active high
);
    // Reset synchroniser, released through two flops
    // Only the second flop feeds the design, so release never lands mid-settle
    reg rstMeta;
    reg rstSyncB;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstSyncB <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncB <= rstMeta;
        end
    end

    // Address decode, used by reads and writes alike
    function isReg;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            isReg = (addr == ofs);
        end
    endfunction

    // Result registers
    reg [15:0] shuntResult;
    reg [15:0] busResult;
    reg [11:0] tempResult;
    reg [15:0] currentResult;
    reg [23:0] powerResult;

    // Configuration bits of the diagnostic register
    reg latchEn;
    reg readyOnPin;
    reg cmpOnAvg;
    reg alertPol;

    // Status flags
    reg overflowFlag;
    reg readyFlag;
    reg memOk;
    reg [5:0] limitFlag;

    // Limit flag slots; the diag word shows them from bit 7 down to bit 2
    localparam FLAG_PWR = 0;
    localparam FLAG_BUS_UNDER_LIMIT_FLAG = 1;
    localparam FLAG_BUS_OVER_LIMIT_FLAG = 2;
    localparam FLAG_SHUL = 3;
    localparam FLAG_SHOL = 4;
    localparam FLAG_TEMP = 5;

    // Reset word of the diagnostic register, source of the bit resets below
    localparam [15:0] RST_DIAG = `PMRA_RST_DIAG;

    wire diagRead;
    wire diagWrite;

    assign diagRead = regRdStrobe && isReg(regAddr, `PMRA_OFS_DIAG);
    assign diagWrite = regWrStrobe && isReg(regAddr, `PMRA_OFS_DIAG);

    // Results load only on a completed (averaged) conversion, per channel
    always @(posedge core_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            shuntResult <= `PMRA_RST_RESULT16;
            busResult <= `PMRA_RST_RESULT16;
            tempResult <= `PMRA_RST_TEMP;
            currentResult <= `PMRA_RST_RESULT16;
            powerResult <= `PMRA_RST_RESULT24;
        end else if (resultValid) begin
            if (resultChan[0]) begin
                shuntResult <= avgShunt;
                currentResult <= calcCurrent;
                powerResult <= calcPower;
            end
            if (resultChan[1]) begin
                busResult <= {1'b0, avgBus[14:0]};
            end
            if (resultChan[2]) begin
                tempResult <= avgTemp;
            end
        end
    end

    // Comparison source: raw sample strobes or the averaged result
    wire [2:0] cmpStrobe;
    wire [15:0] cmpShunt;
    wire [15:0] cmpBus;
    wire [11:0] cmpTemp;

    assign cmpStrobe = cmpOnAvg ? (resultChan & {3{resultValid}}) : rawValid;
    assign cmpShunt = cmpOnAvg ? avgShunt : rawShunt;
    assign cmpBus = cmpOnAvg ? {1'b0, avgBus[14:0]} : {1'b0, rawBus[14:0]};
    assign cmpTemp = cmpOnAvg ? avgTemp : rawTemp;

    wire shuntOver;
    wire shuntUnder;
    wire busOver;
    wire busUnder;
    wire tempOver;
    wire powerOver;

    pmra_limit_cmp #(.WIDTH(16), .SIGNED(1)) shuntCmp (
        .value(cmpShunt),
        .overLim(shuntOverLim),
        .underLim(shuntUnderLim),
        .over(shuntOver),
        .under(shuntUnder)
    );

    // Bus limits are unsigned; bit 15 is forced low on both sides
    pmra_limit_cmp #(.WIDTH(16), .SIGNED(0)) busCmp (
        .value(cmpBus),
        .overLim({1'b0, busOverLim[14:0]}),
        .underLim({1'b0, busUnderLim[14:0]}),
        .over(busOver),
        .under(busUnder)
    );

    pmra_limit_cmp #(.WIDTH(12), .SIGNED(1)) tempCmp (
        .value(cmpTemp),
        .overLim(tempOverLim),
        .underLim(12'h800),
        .over(tempOver),
        .under()
    );

    // Power only exists after the math, so it compares on a completed result that includes the shunt channel
    pmra_limit_cmp #(.WIDTH(24), .SIGNED(0)) powerCmp (
        .value(calcPower),
        .overLim(powerOverLim),
        .underLim(24'h000000),
        .over(powerOver),
        .under()
    );

    // Per-flag strobe and condition; power only ever compares on a completed result
    wire [5:0] flagStrobe;
    wire [5:0] flagCond;

    assign flagStrobe[FLAG_TEMP] = cmpStrobe[2];
    assign flagStrobe[FLAG_SHOL] = cmpStrobe[0];
    assign flagStrobe[FLAG_SHUL] = cmpStrobe[0];
    assign flagStrobe[FLAG_BUS_OVER_LIMIT_FLAG] = cmpStrobe[1];
    assign flagStrobe[FLAG_BUS_UNDER_LIMIT_FLAG] = cmpStrobe[1];
    assign flagStrobe[FLAG_PWR] = resultValid & resultChan[0];
    assign flagCond[FLAG_TEMP] = tempOver;
    assign flagCond[FLAG_SHOL] = shuntOver;
    assign flagCond[FLAG_SHUL] = shuntUnder;
    assign flagCond[FLAG_BUS_OVER_LIMIT_FLAG] = busOver;
    assign flagCond[FLAG_BUS_UNDER_LIMIT_FLAG] = busUnder;
    assign flagCond[FLAG_PWR] = powerOver;

    // Limit flags; in latched mode a new fault beats the read clear
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : limitFlags
            always @(posedge core_clk or negedge rstSyncB) begin
                if (!rstSyncB) begin
                    limitFlag[gi] <= 1'b0;
                end else if (latchEn) begin
                    limitFlag[gi] <= (limitFlag[gi] & ~diagRead)
                                     | (flagStrobe[gi] & flagCond[gi]);
                end else if (flagStrobe[gi]) begin
                    limitFlag[gi] <= flagCond[gi];
                end
            end
        end
    endgenerate

    // Configuration bits written by the host
    always @(posedge core_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            latchEn <= RST_DIAG[`PMRA_BIT_LATCH];
            readyOnPin <= RST_DIAG[`PMRA_BIT_RDYPIN];
            cmpOnAvg <= RST_DIAG[`PMRA_BIT_AVGCMP];
            alertPol <= RST_DIAG[`PMRA_BIT_POL];
        end else if (diagWrite) begin
            latchEn <= regWrData[`PMRA_BIT_LATCH];
            readyOnPin <= regWrData[`PMRA_BIT_RDYPIN];
            cmpOnAvg <= regWrData[`PMRA_BIT_AVGCMP];
            alertPol <= regWrData[`PMRA_BIT_POL];
        end
    end

    // Overflow holds until another conversion is triggered; set wins
    always @(posedge core_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            overflowFlag <= 1'b0;
        end else begin
            overflowFlag <= (overflowFlag & ~convTrigger)
                            | (resultValid & mathOverflow);
        end
    end

    // Ready flag: set on completion, cleared by read or new trigger
    always @(posedge core_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            readyFlag <= 1'b0;
        end else begin
            readyFlag <= (readyFlag & ~diagRead & ~convTrigger) | resultValid;
        end
    end

    // Trim memory status; a checksum failure sticks until reset
    always @(posedge core_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            memOk <= RST_DIAG[`PMRA_BIT_MEMOK];
        end else if (trimChecksumError) begin
            memOk <= 1'b0;
        end
    end

    // Diagnostic word as the host sees it, one field per line
    wire [15:0] diagWord;

    assign diagWord[`PMRA_BIT_LATCH] = latchEn;
    assign diagWord[`PMRA_BIT_RDYPIN] = readyOnPin;
    assign diagWord[`PMRA_BIT_AVGCMP] = cmpOnAvg;
    assign diagWord[`PMRA_BIT_POL] = alertPol;
    assign diagWord[11:10] = 2'b00;
    assign diagWord[`PMRA_BIT_ARITHMETIC_OVERFLOW_FLAG] = overflowFlag;
    assign diagWord[8] = 1'b0;
    assign diagWord[`PMRA_BIT_TEMPOL] = limitFlag[FLAG_TEMP];
    assign diagWord[`PMRA_BIT_SHUNT_OVER_LIMIT_FLAG] = limitFlag[FLAG_SHOL];
    assign diagWord[`PMRA_BIT_SHUNT_UNDER_LIMIT_FLAG] = limitFlag[FLAG_SHUL];
    assign diagWord[`PMRA_BIT_BUS_OVER_LIMIT_FLAG] = limitFlag[FLAG_BUS_OVER_LIMIT_FLAG];
    assign diagWord[`PMRA_BIT_BUS_UNDER_LIMIT_FLAG] = limitFlag[FLAG_BUS_UNDER_LIMIT_FLAG];
    assign diagWord[`PMRA_BIT_PWROL] = limitFlag[FLAG_PWR];
    assign diagWord[`PMRA_BIT_CONVERSION_READY_FLAG] = readyFlag;
    assign diagWord[`PMRA_BIT_MEMOK] = memOk;

    // Registered read mux; unmapped offsets read zero
    // Power high byte rides on its own port, zero for every other offset
    always @(posedge core_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            regRdData <= 16'h0000;
            regRdDataHi <= 8'h00;
        end else if (regRdStrobe) begin
            regRdDataHi <= 8'h00;
            if (isReg(regAddr, `PMRA_OFS_SHUNT)) begin
                regRdData <= shuntResult;
            end else if (isReg(regAddr, `PMRA_OFS_BUS)) begin
                regRdData <= busResult;
            end else if (isReg(regAddr, `PMRA_OFS_TEMP)) begin
                regRdData <= {tempResult, 4'h0};
            end else if (isReg(regAddr, `PMRA_OFS_CURRENT)) begin
                regRdData <= currentResult;
            end else if (isReg(regAddr, `PMRA_OFS_POWER)) begin
                regRdData <= powerResult[15:0];
                regRdDataHi <= powerResult[23:16];
            end else if (isReg(regAddr, `PMRA_OFS_DIAG)) begin
                regRdData <= diagWord;
            end else begin
                regRdData <= 16'h0000;
            end
        end
    end

    // Alert drive; open-drain pin only ever pulls low
    // Registered so the pin cannot glitch while flags resolve
    wire alertCond;

    assign alertCond = (|limitFlag) | (readyOnPin & readyFlag);
    assign alertPinOut = 1'b0;

    always @(posedge core_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            alertActive <= 1'b0;
            alertPinOe <= 1'b0;
        end else begin
            alertActive <= alertCond;
            alertPinOe <= alertPol ? ~alertCond : alertCond;
        end
    end
endmodule

`default_nettype wire

//--- pmra_defs_regs.vh
`ifndef PMRA_DEFS_REGS_VH
`define PMRA_DEFS_REGS_VH

// Register offsets (word addresses on the documented register port)
`define PMRA_OFS_SHUNT 8'h04
`define PMRA_OFS_BUS 8'h05
`define PMRA_OFS_TEMP 8'h06
`define PMRA_OFS_CURRENT 8'h07
`define PMRA_OFS_POWER 8'h08
`define PMRA_OFS_DIAG 8'h0b

// Reset values
`define PMRA_RST_RESULT16 16'h0000
`define PMRA_RST_RESULT24 24'h000000
`define PMRA_RST_DIAG 16'h0001
`define PMRA_RST_TEMP 12'h000

// Diagnostic register bit positions
`define PMRA_BIT_LATCH 15
`define PMRA_BIT_RDYPIN 14
`define PMRA_BIT_AVGCMP 13
`define PMRA_BIT_POL 12
`define PMRA_BIT_ARITHMETIC_OVERFLOW_FLAG 9
`define PMRA_BIT_TEMPOL 7
`define PMRA_BIT_SHUNT_OVER_LIMIT_FLAG 6
`define PMRA_BIT_SHUNT_UNDER_LIMIT_FLAG 5
`define PMRA_BIT_BUS_OVER_LIMIT_FLAG 4
`define PMRA_BIT_BUS_UNDER_LIMIT_FLAG 3
`define PMRA_BIT_PWROL 2
`define PMRA_BIT_CONVERSION_READY_FLAG 1
`define PMRA_BIT_MEMOK 0

// Temperature field position within its result word
`define PMRA_TEMP_MSB 15
`define PMRA_TEMP_LSB 4

`endif

//--- pmra_limit_cmp.v
`timescale 1ns/1ps
`default_nettype none

module pmra_limit_cmp #(
    parameter WIDTH = 16,
    parameter SIGNED = 1
) (
    input wire [WIDTH-1:0] value,    // Measurement under test
    input wire [WIDTH-1:0] overLim,  // Over-limit threshold
    input wire [WIDTH-1:0] underLim, // Under-limit threshold
    output wire over,                // Value above overLim
    output wire under                // Value below underLim
);
    // Flip the sign bit so an unsigned compare orders two's complement values
    wire [WIDTH-1:0] flip;
    wire [WIDTH-1:0] v;
    wire [WIDTH-1:0] o;
    wire [WIDTH-1:0] u;

    assign flip = (SIGNED != 0) ? {1'b1, {(WIDTH-1){1'b0}}} : {WIDTH{1'b0}};
    assign v = value ^ flip;
    assign o = overLim ^ flip;
    assign u = underLim ^ flip;
    assign over = (v > o);
    assign under = (v < u);
endmodule

`default_nettype wire

//--- pmra_result_alert_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pmra_result_alert_monitor (
    input wire core_clk, // Clock
    input wire rst_b, // Async reset
    input wire [7:0] regAddr, // Offset
    input wire regRdStrobe, // Read
    input wire regWrStrobe, // Write
    input wire [15:0] regWrData, // Write data
    input wire [15:0] regRdData, // Read data
    input wire resultValid, // Conversion done
    input wire mathOverflow, // Overflow
    input wire convTrigger, // Trigger
    input wire alertPinOe, // Pin enable
    input wire alertActive // Alert state
);
    reg [3:0] cfg;
    reg ovf;
    reg rdy;
    wire diagRd = regRdStrobe && regAddr == 8'h0b;
    wire rd = regRdStrobe;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // Shadow of diag state; set wins over clear
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= 4'h0;
            ovf <= 1'b0;
            rdy <= 1'b0;
        end else begin
            if (regWrStrobe && regAddr == 8'h0b)
                cfg <= regWrData[15:12];
            ovf <= (resultValid && mathOverflow) || (ovf && !convTrigger);
            rdy <= resultValid || (rdy && !convTrigger && !diagRd);
        end
    end

    // Polarity change skipped: enable lags the new setting by one edge
    AST_OE_POL: assert property (
        $stable(cfg[0]) |-> alertPinOe == (alertActive ^ cfg[0]))
        else $error("pin enable wrong for polarity");
    AST_ALERT_RDY: assert property (
        cfg[2] && rdy |=> alertActive)
        else $error("ready not routed to alert");
    AST_BUS_POS: assert property (
        rd && regAddr == 8'h05 |=> !regRdData[15])
        else $error("bus result negative");
    AST_TEMP_LOW: assert property (
        rd && regAddr == 8'h06 |=> regRdData[3:0] == 4'h0)
        else $error("temperature low nibble set");
    AST_RSV_ZERO: assert property (
        diagRd |=> regRdData[11:10] == 2'b00 && !regRdData[8])
        else $error("reserved diag bits set");
    AST_CFG_RB: assert property (
        diagRd |=> regRdData[15:12] == $past(cfg))
        else $error("diag setting bits wrong");
    AST_OVF_BIT: assert property (
        diagRd |=> regRdData[9] == $past(ovf))
        else $error("overflow bit wrong");
    AST_RDY_BIT: assert property (
        diagRd |=> regRdData[1] == $past(rdy))
        else $error("ready bit wrong");
endmodule

bind pmra_result_alert pmra_result_alert_monitor i_mon (.core_clk, .rst_b, .regAddr,
    .regRdStrobe, .regWrStrobe, .regWrData, .regRdData, .resultValid, .mathOverflow,
    .convTrigger, .alertPinOe, .alertActive);
`default_nettype wire

//--- pmra_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmra_host_model (
    input wire core_clk, // Clock
    input wire [15:0] regRdData, // Read data
    input wire [7:0] regRdDataHi, // Power high byte
    output logic [7:0] regAddr, // Offset
    output logic regRdStrobe, // Read request
    output logic regWrStrobe, // Write request
    output logic [15:0] regWrData // Write data
);
    // Idle from time zero so nothing is requested in reset
    initial {regAddr, regRdStrobe, regWrStrobe, regWrData} = 26'h0;

    // One transfer; released lines show the inverse, not a stale value
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
            output logic [23:0] q);
        @(negedge core_clk);
        {regAddr, regWrData, regRdStrobe, regWrStrobe} = {a, d, !w, w};
        @(negedge core_clk);
        {regAddr, regWrData, regRdStrobe, regWrStrobe} = {~a, ~d, 2'b00};
        q = {regRdDataHi, regRdData};
    endtask
endmodule
`default_nettype wire

//--- power_monitor_result_alert_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module power_monitor_result_alert_regs_test;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] rawValid, resultChan;
    logic [15:0] rawShunt, rawBus, avgShunt, avgBus, calcCurrent, eSh, eBu, eTe, eCu;
    logic [15:0] shuntOverLim, shuntUnderLim, busOverLim, busUnderLim;
    logic [11:0] rawTemp, avgTemp, tempOverLim;
    logic [23:0] calcPower, powerOverLim, ePw;
    logic resultValid, mathOverflow, convTrigger, trimChecksumError, shuntRangeSelect;
    logic [3:0] c;
    logic [5:0] f;
    logic act;
    logic [7:0] ofs [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h00};
    wire [7:0] regAddr, regRdDataHi;
    wire [15:0] regWrData, regRdData;
    wire regRdStrobe, regWrStrobe, alertPinOut, alertPinOe, alertActive;
    int n_fail = 0;
    int compares = 0;

    pmra_host_model host (.core_clk, .regRdData, .regRdDataHi, .regAddr, .regRdStrobe,
        .regWrStrobe, .regWrData);
    pmra_result_alert i_dut (.core_clk, .rst_b, .regAddr, .regRdStrobe, .regWrStrobe,
        .regWrData, .regRdData, .regRdDataHi, .rawValid, .rawShunt, .rawBus, .rawTemp,
        .resultValid, .resultChan, .avgShunt, .avgBus, .avgTemp, .calcCurrent, .calcPower,
        .mathOverflow, .convTrigger, .trimChecksumError, .shuntRangeSelect, .shuntOverLim,
        .shuntUnderLim, .busOverLim, .busUnderLim, .tempOverLim, .powerOverLim,
        .alertPinOut, .alertPinOe, .alertActive);

    initial forever #2.5 core_clk = ~core_clk;

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [23:0] e, input string m);
        logic [23:0] q;
        host.xfer(1'b0, a, 16'h0000, q);
        chk(q, e, m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [23:0] q;
        host.xfer(1'b1, a, d, q);
    endtask
    // Limits that no measurement can cross
    task automatic quiet();
        {shuntOverLim, shuntUnderLim, busOverLim, busUnderLim} = 64'h7fff_8000_7fff_0000;
        tempOverLim = 12'h7ff;
        powerOverLim = 24'hffffff;
    endtask
    task automatic rnd();
        {avgShunt, avgBus, calcCurrent, rawShunt} = {$urandom, $urandom};
        {shuntOverLim, shuntUnderLim, busOverLim, busUnderLim} = {$urandom, $urandom};
        {avgTemp, tempOverLim, calcPower, powerOverLim} = {$urandom, $urandom, 8'h00};
    endtask
    task automatic conv(input logic [2:0] ch);
        @(negedge core_clk);
        {resultChan, resultValid} = {ch, 1'b1};
        @(negedge core_clk);
        resultValid = 1'b0;
        if (ch[0]) {eSh, eCu, ePw} = {avgShunt, calcCurrent, calcPower};
        if (ch[1]) eBu = {1'b0, avgBus[14:0]};
        if (ch[2]) eTe = {avgTemp, 4'h0};
    endtask
    task automatic raw();
        @(negedge core_clk);
        rawValid = 3'h7;
        @(negedge core_clk);
        rawValid = 3'h0;
    endtask
    // Limit flags expected from the averaged values, bit 7 down to bit 2
    function automatic logic [5:0] lim();
        lim = {$signed(avgTemp) > $signed(tempOverLim), $signed(avgShunt) >
            $signed(shuntOverLim), $signed(avgShunt) < $signed(shuntUnderLim),
            avgBus[14:0] > busOverLim[14:0], avgBus[14:0] < busUnderLim[14:0],
            calcPower > powerOverLim};
    endfunction
    function automatic logic [23:0] dg(input logic [3:0] s, input logic [5:0] l,
            input logic o, input logic r);
        dg = {8'h00, s, 2'b00, o, 1'b0, l, r, 1'b1};
    endfunction
    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests use
    initial begin
        #20000;
        n_fail++;
        end_sim();
    end

    initial begin
        {rawValid, resultChan, resultValid, mathOverflow, convTrigger} = 9'h0;
        {trimChecksumError, shuntRangeSelect, rawShunt, rawBus, rawTemp} = 46'h0;
        {avgShunt, avgBus, avgTemp, calcCurrent, calcPower} = 84'h0;
        {eSh, eBu, eTe, eCu, ePw} = 88'h0;
        quiet();
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (3) @(posedge core_clk);
        void'($urandom(32'hb745));
        foreach (ofs[i]) rdchk(ofs[i], {23'h0, i == 5}, "reset");
        $display("test reset done");
        // Partial channel sets must leave other results alone
        for (int i = 0; i < 6; i++) begin
            rnd();
            shuntRangeSelect = 1'($urandom);
            conv(3'($urandom));
            wr(8'h07, 16'($urandom));
            rdchk(8'h04, {8'h00, eSh}, "shunt");
            rdchk(8'h05, {8'h00, eBu}, "bus");
            rdchk(8'h06, {8'h00, eTe}, "temp");
            rdchk(8'h07, {8'h00, eCu}, "current");
            rdchk(8'h08, ePw, "power");
        end
        $display("test results done");
        quiet();
        conv(3'h7);
        // Latched settings first, then transparent, every polarity and routing
        for (int i = 0; i < 8; i++) begin
            c = {!i[2], i[1], 1'b1, i[0]};
            wr(8'h0b, {c, 12'h000});
            rnd();
            if (i == 0) quiet();
            f = lim();
            conv(3'h7);
            @(negedge core_clk);
            act = |f | c[2];
            chk({alertPinOut, alertPinOe}, {1'b0, act ^ c[0]}, "pin");
            chk(alertActive, act, "alert");
            rdchk(8'h0b, dg(c, f, 1'b0, 1'b1), "flags");
            rdchk(8'h0b, dg(c, c[3] ? 6'h0 : f, 1'b0, 1'b0), "reread");
        end
        $display("test flags done");
        wr(8'h0b, 16'h2000);
        quiet();
        mathOverflow = 1'b1;
        conv(3'h7);
        mathOverflow = 1'b0;
        rdchk(8'h0b, 24'h2203, "overflow");
        rdchk(8'h0b, 24'h2201, "overflow kept");
        conv(3'h1);
        convTrigger = 1'b1;
        @(negedge core_clk);
        convTrigger = 1'b0;
        rdchk(8'h0b, 24'h2001, "trigger");
        $display("test overflow done");
        {shuntOverLim, busUnderLim, tempOverLim} = {16'h0100, 16'h0010, 12'h010};
        {rawShunt, rawBus, rawTemp} = {16'h0200, 16'h0000, 12'h020};
        raw();
        rdchk(8'h0b, 24'h2001, "raw ignored");
        wr(8'h0b, 16'h0000);
        raw();
        rdchk(8'h0b, 24'h00c9, "raw compare");
        {rawShunt, rawBus, rawTemp} = {16'h0000, 16'h0020, 12'h000};
        raw();
        rdchk(8'h0b, 24'h0001, "fault gone");
        $display("test raw done");
        @(negedge core_clk);
        trimChecksumError = 1'b1;
        @(negedge core_clk);
        trimChecksumError = 1'b0;
        rdchk(8'h0b, 24'h0000, "trim");
        $display("test trim done");
        end_sim();
    end
endmodule
`default_nettype wire
